// ---- trib_map_pkg.sv ----
// Package for the tributary admission and mapping block: groups, ODU types,
// limits, payload types and the request and answer carriers.
// Assumes one 20 MHz clock domain and a synchronous active-low reset.
package trib_map_pkg;

	// ==========================================================
	// Basic widths
	localparam int NUM_CH = 8;
	localparam int CNT_W = 8;
	localparam int N_W = 5;
	localparam int TS_W = 8;

	// ==========================================================
	// Payload types carried by the tributary groups
	localparam logic [7:0] PT_GROUP_K = 8'h15;
	localparam logic [7:0] PT_GROUP_CN = 8'h16;

	// ==========================================================
	// Per-class unit limits of the fixed-rate groups
	localparam logic [CNT_W-1:0] LIM4_C1 = 8'h50;
	localparam logic [CNT_W-1:0] LIM4_C2 = 8'h28;
	localparam logic [CNT_W-1:0] LIM4_C8 = 8'h0a;
	localparam logic [CNT_W-1:0] LIM4_CBIG = 8'h02;
	localparam logic [CNT_W-1:0] LIM4_CTS = 8'h50;
	localparam logic [CNT_W-1:0] LIM25_C1 = 8'h14;
	localparam logic [CNT_W-1:0] LIM25_C2 = 8'h0a;
	localparam logic [CNT_W-1:0] LIM25_C8 = 8'h02;
	localparam logic [CNT_W-1:0] LIM25_CTS = 8'h14;
	localparam logic [CNT_W-1:0] LIM50_C1 = 8'h28;
	localparam logic [CNT_W-1:0] LIM50_C2 = 8'h14;
	localparam logic [CNT_W-1:0] LIM50_C8 = 8'h05;
	localparam logic [CNT_W-1:0] LIM50_CBIG = 8'h01;
	localparam logic [CNT_W-1:0] LIM50_CTS = 8'h28;
	// Multiplier of n for the one-slot, two-slot and variable classes
	localparam logic [3:0] CN_PER_N = 4'ha;

	// ==========================================================
	// Tributary slot counts of each unit
	localparam logic [TS_W-1:0] TS_ONE = 8'h01;
	localparam logic [TS_W-1:0] TS_TWO = 8'h02;
	localparam logic [TS_W-1:0] TS_EIGHT = 8'h08;
	localparam logic [TS_W-1:0] TS_K31 = 8'h1f;
	localparam logic [TS_W-1:0] TS_CN_ODU3 = 8'h08;
	localparam logic [TS_W-1:0] TS_CN_ODU4 = 8'h14;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		GRP_OPU4 = 2'h0,
		GRP_OPUCN = 2'h1,
		GRP_OPU25 = 2'h2,
		GRP_OPU50 = 2'h3
	} group_t;

	typedef enum logic [2:0] {
		ODU_0 = 3'h0,
		ODU_1 = 3'h1,
		ODU_2 = 3'h2,
		ODU_2E = 3'h3,
		ODU_3 = 3'h4,
		ODU_4 = 3'h5,
		ODU_FLEX = 3'h6
	} odu_t;

	// Unit class: index of the per-group occupancy counter
	typedef enum logic [2:0] {
		CLS_1 = 3'h0,
		CLS_2 = 3'h1,
		CLS_8 = 3'h2,
		CLS_BIG = 3'h3,
		CLS_TS = 3'h4
	} unit_cls_t;
	localparam int NUM_CLS = 5;
	localparam int NUM_GRP = 4;

	// Allowed mapping methods, one bit each
	localparam int M_BMP = 0;
	localparam int M_TTT_GMP = 1;
	localparam int M_GMP = 2;
	localparam int M_GFPF = 3;
	localparam int M_IMP = 4;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic remove;
		group_t group;
		odu_t odu;
		logic [N_W-1:0] n;
		logic [TS_W-1:0] flex_ts;
	} trib_req_t;

	typedef struct packed {
		logic accepted;
		logic cfg_error;
		logic fa_extend;
		logic gmp;
		group_t group;
		unit_cls_t unit_cls;
		logic [TS_W-1:0] slots;
		logic [7:0] payload_type;
		logic [CNT_W-1:0] in_use;
	} trib_resp_t;

	typedef struct packed {
		logic client_pcs;
		logic uni_flexe;
		logic rate_above_100g;
		logic rate_at_100g;
		logic inter_domain;
	} eth_req_t;

endpackage : trib_map_pkg

// ---- odu_trib_mux_map.sv ----
// Tributary admission and mapping control for lower-order ODUs into
// OPU4, OPUCn, OPU25 and OPU50 groups, Ethernet client mapping selection and
// multi-channel OTU supervision.
// Assumes requests from same-clock logic and OTU status pins from outside.
`timescale 1ns/1ps

module odu_trib_mux_map
	import trib_map_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Tributary assignment requests
	input wire logic i_req_valid,
	input wire trib_req_t i_req,
	output logic o_req_ready,
	output logic o_resp_valid,
	output trib_resp_t o_resp,
	// Ethernet client mapping selection
	input wire eth_req_t i_eth,
	output logic [4:0] o_eth_methods,
	// Multi-channel OTU status pins
	input wire logic [NUM_CH-1:0] i_otu_present,
	input wire logic [NUM_CH-1:0] i_otu_trace_mismatch,
	output logic [NUM_CH-1:0] o_otu_in_service,
	output logic o_if_operational,
	output logic o_if_trace_mismatch
);

	// ==========================================================
	// Functions

	// Unit class of an ODU type; ODU2 and ODU2e share the 8-slot units
	function automatic unit_cls_t cls_of(input odu_t odu);
		case (odu)
			ODU_0: cls_of = CLS_1;
			ODU_1: cls_of = CLS_2;
			ODU_2, ODU_2E: cls_of = CLS_8;
			ODU_3, ODU_4: cls_of = CLS_BIG;
			default: cls_of = CLS_TS;
		endcase
	endfunction : cls_of

	// OPUCn class: ODU0 and ODU1 both land in one-slot units
	function automatic unit_cls_t cls_cn(input odu_t odu);
		case (odu)
			ODU_0, ODU_1: cls_cn = CLS_1;
			ODU_2, ODU_2E: cls_cn = CLS_2;
			ODU_3: cls_cn = CLS_8;
			ODU_4: cls_cn = CLS_BIG;
			default: cls_cn = CLS_TS;
		endcase
	endfunction : cls_cn

	// Whether a group offers a unit for this ODU type
	function automatic logic supported(input group_t g, input odu_t odu);
		case (g)
			GRP_OPUCN: supported = 1'b1;
			GRP_OPU4, GRP_OPU50: supported = (odu != ODU_4);
			GRP_OPU25: supported = (odu != ODU_4) && (odu != ODU_3);
			default: supported = 1'b0;
		endcase
	endfunction : supported

	// Unit limit of a class in a group; OPUCn limits scale with n
	function automatic logic [CNT_W-1:0] limit_of(input group_t g, input unit_cls_t c,
			input logic [N_W-1:0] n);
		logic [CNT_W-1:0] ten_n;
		ten_n = CNT_W'(CN_PER_N * n);
		limit_of = '0;
		case (g)
			GRP_OPU4: begin
				case (c)
					CLS_1: limit_of = LIM4_C1;
					CLS_2: limit_of = LIM4_C2;
					CLS_8: limit_of = LIM4_C8;
					CLS_BIG: limit_of = LIM4_CBIG;
					default: limit_of = LIM4_CTS;
				endcase
			end
			GRP_OPU25: begin
				case (c)
					CLS_1: limit_of = LIM25_C1;
					CLS_2: limit_of = LIM25_C2;
					CLS_8: limit_of = LIM25_C8;
					CLS_BIG: limit_of = '0;
					default: limit_of = LIM25_CTS;
				endcase
			end
			GRP_OPU50: begin
				case (c)
					CLS_1: limit_of = LIM50_C1;
					CLS_2: limit_of = LIM50_C2;
					CLS_8: limit_of = LIM50_C8;
					CLS_BIG: limit_of = LIM50_CBIG;
					default: limit_of = LIM50_CTS;
				endcase
			end
			default: begin
				case (c)
					CLS_8: limit_of = CNT_W'((ten_n >> 2)); // floor of 2.5n
					CLS_BIG: limit_of = CNT_W'(n);
					default: limit_of = ten_n;
				endcase
			end
		endcase
	endfunction : limit_of

	// Tributary slots taken by one unit
	function automatic logic [TS_W-1:0] slots_of(input group_t g, input odu_t odu,
			input logic [TS_W-1:0] flex_ts);
		slots_of = flex_ts;
		if (g == GRP_OPUCN) begin
			case (odu)
				ODU_0, ODU_1: slots_of = TS_ONE;
				ODU_2, ODU_2E: slots_of = TS_TWO;
				ODU_3: slots_of = TS_CN_ODU3;
				ODU_4: slots_of = TS_CN_ODU4;
				default: slots_of = flex_ts;
			endcase
		end else begin
			case (odu)
				ODU_0: slots_of = TS_ONE;
				ODU_1: slots_of = TS_TWO;
				ODU_2, ODU_2E: slots_of = TS_EIGHT;
				ODU_3: slots_of = TS_K31;
				default: slots_of = flex_ts;
			endcase
		end
	endfunction : slots_of

	// ==========================================================
	// Admission state machine
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CHECK = 3'b010,
		ST_ANSWER = 3'b100
	} adm_state_t;

	adm_state_t state_q, state_d;
	trib_req_t req_q, req_d;
	trib_resp_t resp_q, resp_d;
	logic [CNT_W-1:0] cnt_q [NUM_GRP][NUM_CLS];
	logic [CNT_W-1:0] cnt_d [NUM_GRP][NUM_CLS];
	unit_cls_t cur_cls;
	logic [CNT_W-1:0] cur_cnt;
	logic [CNT_W-1:0] cur_lim;
	logic ok;

	// Class, occupancy and limit of the held request
	always_comb begin
		cur_cls = (req_q.group == GRP_OPUCN) ? cls_cn(req_q.odu) : cls_of(req_q.odu);
		cur_cnt = cnt_q[req_q.group][cur_cls];
		cur_lim = limit_of(req_q.group, cur_cls, req_q.n);
		if (req_q.remove) begin
			ok = (cur_cnt != '0);
		end else begin
			ok = supported(req_q.group, req_q.odu) && (cur_cnt < cur_lim);
		end
	end

	// Next state, counters and answer
	always_comb begin
		state_d = state_q;
		req_d = req_q;
		resp_d = resp_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (i_req_valid) begin
					req_d = i_req;
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				resp_d.accepted = ok;
				resp_d.cfg_error = !ok;
				resp_d.fa_extend = ok && !req_q.remove;
				resp_d.gmp = ok;
				resp_d.group = req_q.group;
				resp_d.unit_cls = cur_cls;
				resp_d.slots = slots_of(req_q.group, req_q.odu, req_q.flex_ts);
				resp_d.payload_type = (req_q.group == GRP_OPUCN) ? PT_GROUP_CN
					: PT_GROUP_K;
				resp_d.in_use = cur_cnt;
				if (ok && req_q.remove) begin
					cnt_d[req_q.group][cur_cls] = cur_cnt - 1'b1;
					resp_d.in_use = cur_cnt - 1'b1;
				end else if (ok) begin
					cnt_d[req_q.group][cur_cls] = cur_cnt + 1'b1;
					resp_d.in_use = cur_cnt + 1'b1;
				end
				state_d = ST_ANSWER;
			end
			ST_ANSWER: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Admission registers
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_q <= ST_IDLE;
			req_q <= '0;
			resp_q <= '0;
			for (int g = 0; g < NUM_GRP; g++) begin
				for (int c = 0; c < NUM_CLS; c++) begin
					cnt_q[g][c] <= '0;
				end
			end
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			resp_q <= resp_d;
			cnt_q <= cnt_d;
		end
	end

	// Handshake outputs
	assign o_req_ready = (state_q == ST_IDLE);
	assign o_resp_valid = (state_q == ST_ANSWER);
	assign o_resp = resp_q;

	// ==========================================================
	// Ethernet client mapping selection
	logic [4:0] meth_q, meth_d;

	// Allowed methods; at exactly 100G a MAC client not crossing domains also gets IMP
	always_comb begin
		meth_d = '0;
		if (i_eth.client_pcs) begin
			if (i_eth.inter_domain || !i_eth.uni_flexe) begin
				meth_d[M_BMP] = 1'b1;
				meth_d[M_TTT_GMP] = 1'b1;
				meth_d[M_GMP] = 1'b1;
			end else begin
				meth_d[M_IMP] = 1'b1;
			end
		end else if (i_eth.rate_above_100g) begin
			meth_d[M_IMP] = 1'b1;
		end else if (i_eth.inter_domain) begin
			meth_d[M_GFPF] = 1'b1;
		end else if (i_eth.uni_flexe) begin
			meth_d[M_IMP] = 1'b1;
		end else begin
			meth_d[M_GFPF] = 1'b1;
			meth_d[M_IMP] = 1'b1;
		end
		if (!i_eth.client_pcs && i_eth.rate_at_100g && !i_eth.inter_domain) begin
			meth_d[M_IMP] = 1'b1;
		end
	end

	// Method register
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			meth_q <= '0;
		end else begin
			meth_q <= meth_d;
		end
	end

	assign o_eth_methods = meth_q;

	// ==========================================================
	// Multi-channel OTU supervision
	// Three stages per pin; a change counts once stages two and three agree
	logic [NUM_CH-1:0] pres_s1_q, pres_s2_q, pres_s3_q, pres_q, pres_d;
	logic [NUM_CH-1:0] tim_s1_q, tim_s2_q, tim_s3_q, tim_q, tim_d;
	logic oper_q, oper_d;
	logic mis_q, mis_d;

	// Filtered levels and interface-wide results
	always_comb begin
		pres_d = pres_q;
		tim_d = tim_q;
		for (int i = 0; i < NUM_CH; i++) begin
			if (pres_s2_q[i] == pres_s3_q[i]) begin
				pres_d[i] = pres_s3_q[i];
			end
			if (tim_s2_q[i] == tim_s3_q[i]) begin
				tim_d[i] = tim_s3_q[i];
			end
		end
		oper_d = |pres_d;
		mis_d = |(tim_d & pres_d);
	end

	// Synchroniser and status registers
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pres_s1_q <= '0;
			pres_s2_q <= '0;
			pres_s3_q <= '0;
			tim_s1_q <= '0;
			tim_s2_q <= '0;
			tim_s3_q <= '0;
			pres_q <= '0;
			tim_q <= '0;
			oper_q <= 1'b0;
			mis_q <= 1'b0;
		end else begin
			pres_s1_q <= i_otu_present;
			pres_s2_q <= pres_s1_q;
			pres_s3_q <= pres_s2_q;
			tim_s1_q <= i_otu_trace_mismatch;
			tim_s2_q <= tim_s1_q;
			tim_s3_q <= tim_s2_q;
			pres_q <= pres_d;
			tim_q <= tim_d;
			oper_q <= oper_d;
			mis_q <= mis_d;
		end
	end

	assign o_otu_in_service = pres_q;
	assign o_if_operational = oper_q;
	assign o_if_trace_mismatch = mis_q;

endmodule : odu_trib_mux_map

// ---- trib_map_props.sv ----
// Checker for the tributary mapping block: answer timing and contents, Ethernet methods and the operational flag.
// Assumes binding to the top module, one clock, synchronous reset.
`timescale 1ns/1ps
module trib_map_props
	import trib_map_pkg::*;
(
	// Watched ports
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_req_valid,
	input wire trib_req_t i_req,
	input wire eth_req_t i_eth,
	input wire logic o_req_ready,
	input wire logic o_resp_valid,
	input wire trib_resp_t o_resp,
	input wire logic [4:0] o_eth_methods,
	input wire logic [NUM_CH-1:0] o_otu_in_service,
	input wire logic o_if_operational
);
	// ========
	// Properties
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_answer_two_cycles: assert property (i_req_valid && o_req_ready |-> ##2 o_resp_valid)
		else $error("answer not two cycles after take");
	a_busy_after_take: assert property (i_req_valid && o_req_ready |=> !o_req_ready [*2])
		else $error("ready back too early");
	a_pt_group_cn: assert property (o_resp_valid && o_resp.accepted &&
		o_resp.group == GRP_OPUCN |-> o_resp.payload_type == PT_GROUP_CN)
		else $error("wrong payload type for OPUCn");
	a_pt_group_k: assert property (o_resp_valid && o_resp.accepted &&
		o_resp.group != GRP_OPUCN |-> o_resp.payload_type == PT_GROUP_K)
		else $error("wrong payload type for fixed group");
	// Removals free a unit, so framing is only added on accepted additions
	a_gmp_framing: assert property (o_resp_valid && o_resp.accepted |-> o_resp.gmp &&
		(o_resp.fa_extend == !$past(i_req.remove, 2)))
		else $error("unit without GMP or framing");
	a_cn_big_slots: assert property (o_resp_valid && o_resp.accepted &&
		o_resp.group == GRP_OPUCN && o_resp.unit_cls == CLS_BIG |-> o_resp.slots == TS_CN_ODU4)
		else $error("wrong slot count for big OPUCn unit");
	a_pcs_flexe_imp: assert property (i_eth.client_pcs && i_eth.uni_flexe &&
		!i_eth.inter_domain |=> o_eth_methods == 5'h10)
		else $error("PCS over FlexE not IMP");
	a_mac_xdom_gfpf: assert property (!i_eth.client_pcs && i_eth.inter_domain &&
		!i_eth.rate_above_100g |=> o_eth_methods == 5'h08)
		else $error("MAC crossing not GFP-F");
	a_oper_any: assert property (o_if_operational == (|o_otu_in_service))
		else $error("operational not any channel");
endmodule : trib_map_props

// ---- otu_src_model.sv ----
// Far-side model of the multi-channel OTU pins: presence and trace reports.
// Assumes the bench sets targets; pins follow after a chosen lag.
`timescale 1ns/1ps
module otu_src_model (
	// Clock
	input wire logic i_clk,
	// Targets and lag
	input wire logic [7:0] i_pres,
	input wire logic [7:0] i_mm,
	input wire logic [3:0] i_lag,
	// Pins toward the design
	output logic [7:0] o_pres,
	output logic [7:0] o_mm
);
	logic [3:0] wait_q = 4'h0;

	// ========
	// Pin update, all channels at once, prompt or slow
	initial begin
		o_pres = 8'h00;
		o_mm = 8'h00;
	end
	always @(posedge i_clk) begin
		if ({i_pres, i_mm} != {o_pres, o_mm}) begin
			if (wait_q >= i_lag) begin
				o_pres <= i_pres;
				o_mm <= i_mm;
				wait_q <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule : otu_src_model

// ---- tb_odu_trib_mux_map.sv ----
// Testbench: admission limits, Ethernet method masks, channel supervision.
// Assumes package, design, checker and OTU model compiled first.
`timescale 1ns/1ps
module tb_odu_trib_mux_map;
	import trib_map_pkg::*;
	// ========
	// Signals
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_req_valid = 1'b0;
	trib_req_t i_req = '0;
	eth_req_t i_eth = '0;
	logic [7:0] tp = 8'h00;
	logic [7:0] tm = 8'h00;
	logic [3:0] lag = 4'h0;
	logic [7:0] pres, mm, o_otu_in_service;
	logic o_req_ready, o_resp_valid, o_if_operational, o_if_trace_mismatch;
	trib_resp_t o_resp;
	logic [4:0] o_eth_methods;
	logic [7:0] pat[6] = '{8'h20, 8'h21, 8'h01, 8'h00, 8'h80, 8'hff};
	logic [7:0] mpat[6] = '{8'h00, 8'h20, 8'h02, 8'hff, 8'h80, 8'h7f};
	int bad_count = 0;
	int checks_done = 0;
	integer seed = 32'h0a897122;

	always #25 i_clk = ~i_clk;

	odu_trib_mux_map i_odu_trib_mux_map (.i_clk, .i_reset_n, .i_req_valid, .i_req, .o_req_ready,
		.o_resp_valid, .o_resp, .i_eth, .o_eth_methods, .i_otu_present(pres),
		.i_otu_trace_mismatch(mm), .o_otu_in_service, .o_if_operational, .o_if_trace_mismatch);
	otu_src_model i_otu_src_model (.i_clk, .i_pres(tp), .i_mm(tm), .i_lag(lag), .o_pres(pres),
		.o_mm(mm));

	// ========
	// Helpers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// Held until taken; answer sampled one edge after the taking edge
	task automatic req(input logic rm, input group_t g, input odu_t o, input logic [4:0] n,
			input logic a, input logic [7:0] s);
		int k;
		k = 0;
		i_req = '{rm, g, o, n, 8'h03};
		i_req_valid = 1'b1;
		while (o_req_ready !== 1'b1 && k < 8) begin
			@(posedge i_clk);
			#5 k++;
		end
		if (k == 8) begin
			bad_count++;
			wrap_up();
		end
		@(posedge i_clk);
		#5 i_req_valid = 1'b0;
		@(posedge i_clk);
		#5 chk("answer strobe", 1, o_resp_valid);
		chk("accepted", a, o_resp.accepted);
		chk("error flag", !a, o_resp.cfg_error);
		if (a && !rm) chk("slots", s, o_resp.slots);
		if (a && !rm) chk("gmp and framing", 2'b11, {o_resp.gmp, o_resp.fa_extend});
		chk("payload type", g == GRP_OPUCN ? PT_GROUP_CN : PT_GROUP_K, o_resp.payload_type);
	endtask : req

	function automatic logic [4:0] eth_exp(input eth_req_t e);
		if (e.client_pcs) return (e.uni_flexe && !e.inter_domain) ? 5'h10 : 5'h07;
		if (e.rate_above_100g) return 5'h10;
		if (e.inter_domain) return 5'h08;
		return e.uni_flexe ? 5'h10 : 5'h18;
	endfunction : eth_exp

	// ========
	// Main sequence
	initial begin
		repeat (3) @(posedge i_clk);
		#5 i_reset_n = 1'b1;
		repeat (2) req(0, GRP_OPU4, ODU_3, 0, 1, TS_K31);
		req(0, GRP_OPU4, ODU_3, 0, 0, 0);
		req(1, GRP_OPU4, ODU_3, 0, 1, 0);
		req(0, GRP_OPU4, ODU_3, 0, 1, TS_K31);
		req(0, GRP_OPU4, ODU_4, 0, 0, 0);
		req(1, GRP_OPU25, ODU_0, 0, 0, 0);
		req(0, GRP_OPU25, ODU_3, 0, 0, 0);
		req(0, GRP_OPU25, ODU_2E, 0, 1, TS_EIGHT);
		req(0, GRP_OPU25, ODU_2, 0, 1, TS_EIGHT);
		req(0, GRP_OPU25, ODU_2, 0, 0, 0);
		req(0, GRP_OPU50, ODU_3, 0, 1, TS_K31);
		req(0, GRP_OPU50, ODU_3, 0, 0, 0);
		repeat (2) req(0, GRP_OPUCN, ODU_4, 2, 1, TS_CN_ODU4);
		req(0, GRP_OPUCN, ODU_4, 2, 0, 0);
		req(0, GRP_OPUCN, ODU_2E, 2, 1, TS_TWO);
		req(0, GRP_OPUCN, ODU_0, 2, 1, TS_ONE);
		repeat (2) req(0, GRP_OPUCN, ODU_3, 1, 1, TS_CN_ODU3);
		req(0, GRP_OPUCN, ODU_3, 1, 0, 0);
		req(0, GRP_OPU25, ODU_FLEX, 0, 1, 8'h03);
		for (int k = 0; k < 41; k++) begin
			req(0, GRP_OPU4, ODU_1, 0, k < 40, TS_TWO);
			chk("in use", k < 40 ? k + 1 : 40, o_resp.in_use);
		end
		for (int k = 0; k < 6; k++) req(0, GRP_OPU50, $random(seed) & 1 ? ODU_2 : ODU_2E, 0, k < 5, TS_EIGHT);
		$display("test admission done");
		for (int k = 0; k < 32; k++) begin
			i_eth = eth_req_t'(5'($random(seed)));
			if (i_eth.rate_above_100g) i_eth.rate_at_100g = 1'b0;
			@(posedge i_clk);
			#5 chk("eth methods", eth_exp(i_eth), o_eth_methods);
		end
		$display("test ethernet done");
		for (int k = 0; k < 12; k++) begin
			tp = k < 6 ? pat[k] : 8'($random(seed));
			tm = k < 6 ? mpat[k] : 8'($random(seed));
			lag = 4'(k % 4);
			repeat (lag + 6) @(posedge i_clk);
			#5 chk("in service", tp, o_otu_in_service);
			chk("operational", |tp, o_if_operational);
			chk("trace mismatch", |(tp & tm), o_if_trace_mismatch);
		end
		$display("test channels done");
		i_reset_n = 1'b0;
		@(posedge i_clk);
		#5 i_reset_n = 1'b1;
		chk("ready after reset", 1, o_req_ready);
		req(0, GRP_OPU50, ODU_3, 0, 1, TS_K31);
		$display("test second reset done");
		wrap_up();
	end
endmodule : tb_odu_trib_mux_map

bind odu_trib_mux_map trib_map_props i_trib_map_props (.i_clk, .i_reset_n, .i_req_valid, .i_req,
	.i_eth,
	.o_req_ready, .o_resp_valid, .o_resp, .o_eth_methods, .o_otu_in_service, .o_if_operational);
